// ---- emb_ctrl.v ----
// Overview of operation
// - Each memory cycle has an address phase then a data phase.
// - With hold enabled, sample hold request at end of data phase.
// - Hold request low holds off the next cycle and floats every interface pin.
// - Pins are driven again once hold request is seen high.
// - Grant acknowledge goes low while the interface pins are floated.
// - Low port carries multiplexed address low byte and data byte.
// - High port outputs address high byte.
// - With wait enabled, sample wait in address and data phases.
// - Each active wait sample adds one cycle and samples again.
// - Wait in address phase stretches address strobe, in data phase data strobe.
// - Strobe style set: address pin becomes active high latch enable.
// - Strobe style set: data strobe is read enable, held high on writes.
// - Strobe style set: direction pin is write enable, held high on reads.
// - Second strobe serves lower block when enabled, else held high.
// - Address strobe alternate output enabled or disabled by a bit.
// - Toggle bit, with protection off, lets pins and address strobe move on internal accesses, never the data strobes.
// - Segment frame clear: push only counter and flags, handler uses irq segment.
// - Segment frame set: push code segment too, reload it, restore on return.
// - Remap bit swaps page registers with port data registers.
// - Lower block adds 0 to 3 address strobe cycles, reset 3.
// - Upper block adds 0 to 3 address strobe cycles, reset 3.
`include "emb_map.vh"
module emb_ctrl (
    input  wire        clk,                  // 100 MHz clock
    input  wire        rst_n,                // Async reset, active low
    input  wire        psel,                 // APB select
    input  wire        penable,              // APB enable
    input  wire        pwrite,               // APB direction
    input  wire [11:0] paddr,                // APB byte address
    input  wire [31:0] pwdata,               // APB write data
    output reg  [31:0] prdata,               // APB read data
    output reg         pready,               // APB ready
    output reg         pslverr,              // APB error
    input  wire        acc_req,              // Core access request, held
    input  wire        acc_ext,              // Access targets external memory
    input  wire        acc_wr,               // Access is a write
    input  wire [21:0] acc_addr,             // Access address
    input  wire [7:0]  acc_wdata,            // Write byte
    input  wire        protect_off,          // Internal memory protection off
    output reg         acc_done_q,           // Access finished pulse
    output reg  [7:0]  acc_rdata_q,          // Read byte
    input  wire        bus_hold_request_n,   // Hold request pin
    output reg         grant_ack_n_q,        // Grant acknowledge pin
    input  wire        wait_n,               // Wait pin
    output reg         addr_strobe_n_q,      // Address strobe pin level
    output reg         addr_strobe_oe_q,     // Address strobe drive
    output reg         data_strobe_n_q,      // Data strobe pin level
    output reg         data_strobe_oe_q,     // Data strobe drive
    output reg         lower_block_strobe_n_q, // Second strobe level
    output reg         lower_block_strobe_oe_q, // Second strobe drive
    output reg         rw_q,                 // Direction pin level
    output reg         rw_oe_q,              // Direction pin drive
    input  wire [7:0]  low_port_in,          // Low port pin input
    output reg  [7:0]  low_port_out_q,       // Low port address or data
    output reg         low_port_oe_q,        // Low port drive
    output reg  [7:0]  high_port_out_q,      // High port address
    output reg         high_port_oe_q,       // High port drive
    output reg         output_drive_size_q,  // Large output buffers
    output reg         memory_select_q,      // Memory selection bit
    output reg         push_code_seg_q,      // Irq entry pushes code segment
    output reg         handler_uses_irq_seg_q, // Handler runs from irq segment
    output reg         page_reg_remap_q      // Page regs swapped with port data
);
    // One-hot states; stretch states reuse their phase's pin logic
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_T1   = 7'h02;
    localparam [6:0] ST_T1W  = 7'h04;
    localparam [6:0] ST_T2   = 7'h08;
    localparam [6:0] ST_T2W  = 7'h10;
    localparam [6:0] ST_HOLD = 7'h20;
    localparam [6:0] ST_REL  = 7'h40;

    // Configuration registers and sequencer state
    reg  [7:0] cfg_one_q;
    reg  [7:0] cfg_two_q;
    reg  [7:0] core_mode_q;
    reg  [7:0] irq_vector_q;
    reg  [6:0] state_q;
    reg  [1:0] stretch_q;
    reg        cur_ext_q;
    reg        cur_wr_q;
    reg        cur_upper_q;
    reg  [2:0] hold_sync_q;
    reg  [2:0] wait_sync_q;
    reg        hold_n_f_q;
    reg        wait_n_f_q;
    reg        lp_oe_save_q;
    // Decoded configuration and bus qualifiers
    wire       hold_en  = core_mode_q[`EMB_BIT_HOLD_EN];
    wire       wait_en  = irq_vector_q[`EMB_BIT_WAIT_EN];
    wire       style    = cfg_one_q[`EMB_BIT_STYLE];
    wire       strobe2  = cfg_one_q[`EMB_BIT_STROBE2];
    wire       as_alt   = cfg_one_q[`EMB_BIT_AS_ALT];
    wire       tog      = cfg_one_q[`EMB_BIT_TOGGLE] & protect_off;
    wire       waiting  = wait_en & ~wait_n_f_q;
    wire [7:0] reg_idx  = paddr[9:2];
    wire       setup    = psel & ~penable;
    wire       wr_fire  = psel & penable & pready & pwrite;

    // Read mux and decode; unmapped or misaligned gives an error
    function [8:0] rd_word;
        input [7:0] idx;
        begin
            case (idx)
                `EMB_IDX_CORE_MODE:  rd_word = {1'b1, core_mode_q};
                `EMB_IDX_IRQ_VECTOR: rd_word = {1'b1, irq_vector_q};
                `EMB_IDX_STATUS:     rd_word = {1'b1, 5'h00, (state_q != ST_IDLE), ~grant_ack_n_q, hold_en};
                `EMB_IDX_CFG_ONE:    rd_word = {1'b1, cfg_one_q | `EMB_FIX_CFG_ONE};
                `EMB_IDX_CFG_TWO:    rd_word = {1'b1, cfg_two_q};
                default:             rd_word = 9'h000;
            endcase
        end
    endfunction

    // Decoded read word; an unmapped index reads zero
    wire [8:0] rd_sel   = rd_word(reg_idx);
    wire       bad_addr = ~rd_sel[8] | (paddr[1:0] != 2'b00) | (paddr[11:10] != 2'b00);

    // Address stretch for the addressed block
    // Internal accesses never use it, so the core is not slowed
    function [1:0] stretch_for;
        input upper;
        begin
            if (upper) begin
                stretch_for = cfg_two_q[`EMB_UAS_HI:`EMB_UAS_LO];
            end else begin
                stretch_for = cfg_two_q[`EMB_LAS_HI:`EMB_LAS_LO];
            end
        end
    endfunction

    // Hold pin: a change counts once stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_sync_q <= 3'h7;
            hold_n_f_q  <= 1'b1;
        end else begin
            hold_sync_q <= {hold_sync_q[1:0], bus_hold_request_n};
            // A one-cycle glitch never reaches the sequencer
            if (hold_sync_q[1] == hold_sync_q[2]) begin
                hold_n_f_q <= hold_sync_q[2];
            end
        end
    end

    // Wait pin, same filter; about four cycles pass before a wait counts
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_sync_q <= 3'h7;
            wait_n_f_q  <= 1'b1;
        end else begin
            wait_sync_q <= {wait_sync_q[1:0], wait_n};
            if (wait_sync_q[1] == wait_sync_q[2]) begin
                wait_n_f_q <= wait_sync_q[2];
            end
        end
    end

    // APB slave: answer one cycle after setup, writes land on the ready edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata       <= 32'h00000000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            cfg_one_q    <= `EMB_RST_CFG_ONE;
            cfg_two_q    <= `EMB_RST_CFG_TWO;
            core_mode_q  <= `EMB_RST_CORE_MODE;
            irq_vector_q <= `EMB_RST_IRQ_VECTOR;
        end else begin
            // No wait states: ready follows setup by one cycle
            pready <= setup;
            if (setup) begin
                prdata  <= {24'h000000, rd_sel[7:0]};
                // Known at setup, so a refused write never lands
                pslverr <= bad_addr;
            end
            if (wr_fire && !pslverr) begin
                case (reg_idx)
                    `EMB_IDX_CORE_MODE:  core_mode_q  <= pwdata[7:0];
                    `EMB_IDX_IRQ_VECTOR: irq_vector_q <= pwdata[7:0];
                    `EMB_IDX_CFG_ONE:    cfg_one_q    <= pwdata[7:0] & `EMB_WMASK_CFG_ONE;
                    `EMB_IDX_CFG_TWO:    cfg_two_q    <= pwdata[7:0] & `EMB_WMASK_CFG_TWO;
                    default:             cfg_one_q    <= cfg_one_q;
                endcase
            end
        end
    end

    // Configuration bits handed to the core and pads
    // One cycle of lag; software settles them before use
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_drive_size_q    <= 1'b0;
            memory_select_q        <= 1'b0;
            push_code_seg_q        <= 1'b0;
            handler_uses_irq_seg_q <= 1'b1;
            page_reg_remap_q       <= 1'b0;
        end else begin
            output_drive_size_q    <= cfg_one_q[`EMB_BIT_DRIVE];
            memory_select_q        <= cfg_two_q[`EMB_BIT_MEMORY_SELECT];
            push_code_seg_q        <= cfg_two_q[`EMB_BIT_SEGFRAME];
            handler_uses_irq_seg_q <= ~cfg_two_q[`EMB_BIT_SEGFRAME];
            page_reg_remap_q       <= cfg_two_q[`EMB_BIT_REMAP];
        end
    end

    // Memory cycle sequencer and registered pin drive
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q                 <= ST_IDLE;
            stretch_q               <= 2'h0;
            cur_ext_q               <= 1'b0;
            cur_wr_q                <= 1'b0;
            cur_upper_q             <= 1'b0;
            acc_done_q              <= 1'b0;
            acc_rdata_q             <= 8'h00;
            grant_ack_n_q           <= 1'b1;
            addr_strobe_n_q         <= 1'b1;
            addr_strobe_oe_q        <= 1'b0;
            data_strobe_n_q         <= 1'b1;
            data_strobe_oe_q        <= 1'b0;
            lower_block_strobe_n_q  <= 1'b1;
            lower_block_strobe_oe_q <= 1'b0;
            rw_q                    <= 1'b1;
            rw_oe_q                 <= 1'b0;
            low_port_out_q          <= 8'h00;
            low_port_oe_q           <= 1'b0;
            high_port_out_q         <= 8'h00;
            high_port_oe_q          <= 1'b0;
            lp_oe_save_q            <= 1'b0;
        end else begin
            // One-cycle pulse; the core drops its request then
            acc_done_q <= 1'b0;
            if (state_q != ST_HOLD) begin
                // Strobe style changes pin senses, never the drive enables
                addr_strobe_oe_q        <= as_alt;
                data_strobe_oe_q        <= 1'b1;
                lower_block_strobe_oe_q <= 1'b1;
                rw_oe_q                 <= 1'b1;
                high_port_oe_q          <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    addr_strobe_n_q        <= ~style;
                    data_strobe_n_q        <= 1'b1;
                    lower_block_strobe_n_q <= 1'b1;
                    if (acc_req) begin
                        cur_ext_q   <= acc_ext;
                        cur_wr_q    <= acc_wr;
                        cur_upper_q <= acc_addr[`EMB_ADDR_BLOCK_BIT];
                        stretch_q   <= stretch_for(acc_addr[`EMB_ADDR_BLOCK_BIT]);
                        state_q     <= ST_T1;
                        // With tog set, internal accesses move address pins and address strobe, never data strobes
                        if (acc_ext || tog) begin
                            addr_strobe_n_q <= style;
                            low_port_out_q  <= acc_addr[7:0];
                            low_port_oe_q   <= 1'b1;
                            high_port_out_q <= acc_addr[15:8];
                            rw_q            <= (style && acc_ext) ? 1'b1 : ~acc_wr;
                        end
                    end
                end
                ST_T1, ST_T1W: begin
                    // Programmed stretch first, then the wait pin
                    if (cur_ext_q && stretch_q != 2'h0) begin
                        stretch_q <= stretch_q - 2'h1;
                        state_q   <= ST_T1W;
                    end else if (cur_ext_q && waiting) begin
                        state_q <= ST_T1W;
                    end else begin
                        state_q         <= ST_T2;
                        addr_strobe_n_q <= ~style;
                        if (cur_ext_q) begin
                            if (cur_wr_q) begin
                                low_port_out_q <= acc_wdata;
                                if (style) begin
                                    rw_q <= 1'b0;
                                end
                            end else begin
                                low_port_oe_q <= 1'b0;
                            end
                            // Read enable in style mode, plain strobe otherwise
                            if (strobe2 && !cur_upper_q) begin
                                lower_block_strobe_n_q <= style & cur_wr_q;
                            end else begin
                                data_strobe_n_q <= style & cur_wr_q;
                            end
                        end
                    end
                end
                ST_T2, ST_T2W: begin
                    if (cur_ext_q && waiting) begin
                        state_q <= ST_T2W;
                    end else begin
                        data_strobe_n_q        <= 1'b1;
                        lower_block_strobe_n_q <= 1'b1;
                        acc_done_q             <= 1'b1;
                        if (cur_ext_q && style) begin
                            rw_q <= 1'b1;
                        end
                        // Read data taken on the edge ending the data phase
                        if (!cur_wr_q) begin
                            acc_rdata_q <= low_port_in;
                        end
                        // Kept so a release restores the low port as it was
                        lp_oe_save_q <= low_port_oe_q;
                        // Hold only between cycles, so none is cut short
                        if (hold_en && !hold_n_f_q) begin
                            state_q <= ST_HOLD;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_HOLD: begin
                    // Everything floats while the other master owns the bus
                    addr_strobe_oe_q        <= 1'b0;
                    data_strobe_oe_q        <= 1'b0;
                    lower_block_strobe_oe_q <= 1'b0;
                    rw_oe_q                 <= 1'b0;
                    low_port_oe_q           <= 1'b0;
                    high_port_oe_q          <= 1'b0;
                    grant_ack_n_q           <= 1'b0;
                    if (hold_n_f_q) begin
                        state_q <= ST_REL;
                    end
                end
                ST_REL: begin
                    // Drive is back this cycle, so grant is withdrawn with it
                    grant_ack_n_q <= 1'b1;
                    low_port_oe_q <= lp_oe_save_q;
                    state_q       <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- emb_ctrl_sva.sv ----
module emb_ctrl_sva (
    input wire logic clk, rst_n, psel, penable, pready,             // Clock, reset, APB handshake
    input wire logic acc_done_q, grant_ack_n_q, bus_hold_request_n, // Access end, hold pins
    input wire logic wait_n, addr_strobe_oe_q, data_strobe_oe_q,    // Wait pin, strobe drives
    input wire logic data_strobe_n_q, lower_block_strobe_n_q,       // Data strobe levels
    input wire logic lower_block_strobe_oe_q, rw_q, rw_oe_q,        // Second strobe drive, direction
    input wire logic low_port_oe_q, high_port_oe_q                  // Port drives
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Granted bus means every interface pin floats
    a_grant_floats: assert property (!grant_ack_n_q |-> {low_port_oe_q, high_port_oe_q, rw_oe_q,
        data_strobe_oe_q, addr_strobe_oe_q, lower_block_strobe_oe_q} == 6'h00) else $error("pin driven in hold");
    a_grant_release: assert property ($rose(grant_ack_n_q) |-> high_port_oe_q && rw_oe_q && data_strobe_oe_q)
        else $error("grant released before pins driven");
    a_hold_bounded: assert property ((!grant_ack_n_q && bus_hold_request_n) [*8] |=> grant_ack_n_q)
        else $error("grant kept after request withdrawn");
    // Filter delay means the pin was low well before the grant
    a_grant_cause: assert property ($fell(grant_ack_n_q) |-> !$past(bus_hold_request_n, 2))
        else $error("grant without request");
    a_wait_stall: assert property ((!wait_n) [*6] |-> !acc_done_q)
        else $error("access ended during wait");
    a_one_strobe: assert property (data_strobe_n_q || lower_block_strobe_n_q)
        else $error("both data strobes low");
    a_read_float: assert property ($fell(data_strobe_n_q) && rw_q |-> !low_port_oe_q)
        else $error("low port driven on read");
    a_write_drive: assert property ($fell(data_strobe_n_q) && !rw_q |-> low_port_oe_q)
        else $error("low port floats on write");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    a_done_pulse: assert property (acc_done_q |=> !acc_done_q)
        else $error("done longer than one cycle");
endmodule

bind emb_ctrl emb_ctrl_sva u_emb_ctrl_sva (.*);

// ---- emb_ctrl_tb_top.sv ----
`include "emb_map.vh"
module emb_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, acc_req, acc_ext, acc_wr, protect_off;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [21:0] acc_addr, a;
    logic [7:0]  acc_wdata, acc_rdata_q, low_port_in, low_port_out_q, high_port_out_q, rd;
    logic        acc_done_q, bus_hold_request_n, grant_ack_n_q, wait_n, addr_strobe_n_q, addr_strobe_oe_q;
    logic        data_strobe_n_q, data_strobe_oe_q, lower_block_strobe_n_q, lower_block_strobe_oe_q, rw_q, rw_oe_q;
    logic        low_port_oe_q, high_port_oe_q, output_drive_size_q, memory_select_q, push_code_seg_q;
    logic        handler_uses_irq_seg_q, page_reg_remap_q, style, hold_cmd, lb, e;
    logic [3:0]  wait_len;
    logic [15:0] last_addr;
    logic [2:0]  seen;
    int          n_errors, total_checks, lat, base;
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin n_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, x); end end

    emb_ctrl u_emb_ctrl (.*);
    emb_mem_model u_emb_mem_model (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // One APB transfer; request held until ready is seen at an edge
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'b00, idx, 2'b00}; pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Core access; request must drop inside the done cycle or it restarts
    task acc(input logic ext, input logic wr, input logic [21:0] ad, input logic [7:0] d);
        @(posedge clk);
        acc_ext <= ext; acc_wr <= wr; acc_addr <= ad; acc_wdata <= d; acc_req <= 1'b1;
        lat = 0;
        seen = 3'b111;
        do begin
            @(posedge clk);
            #1;
            lat++;
            seen &= {data_strobe_n_q, lower_block_strobe_n_q, rw_q};
        end while (acc_done_q !== 1'b1);
        acc_req <= 1'b0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests use
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish;
    end

    initial begin
        {rst_n, psel, penable, pwrite, acc_req, acc_ext, acc_wr, protect_off, style, hold_cmd} = 10'h0;
        {paddr, pwdata, acc_addr, acc_wdata, wait_len} = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb(0, `EMB_IDX_CFG_ONE, 8'h00); `CHK(rd, 8'h80)
        apb(0, `EMB_IDX_CFG_TWO, 8'h00); `CHK(rd, 8'h0f)
        apb(0, `EMB_IDX_CORE_MODE, 8'h00); `CHK(rd, 8'h00)
        apb(0, 8'h10, 8'h00); `CHK(e, 1'b1)
        apb(1, `EMB_IDX_CFG_ONE, 8'h7f); apb(0, `EMB_IDX_CFG_ONE, 8'h00); `CHK(rd, 8'hf6)
        `CHK(output_drive_size_q, 1'b1)
        // Written from main flow only, never from a handler
        apb(1, `EMB_IDX_CFG_TWO, 8'hff); apb(0, `EMB_IDX_CFG_TWO, 8'h00); `CHK(rd, 8'h7f)
        `CHK({push_code_seg_q, handler_uses_irq_seg_q, page_reg_remap_q, memory_select_q}, 4'hb)
        apb(1, `EMB_IDX_CFG_TWO, 8'h10);
        repeat (2) @(posedge clk);
        `CHK({push_code_seg_q, handler_uses_irq_seg_q, page_reg_remap_q}, 3'h2)
        $display("end of test: registers");
        // Address strobe stretch, lower then upper block
        for (int u = 0; u < 2; u++) for (int s = 0; s < 4; s++) begin
            apb(1, `EMB_IDX_CFG_TWO, 8'h10 | 8'(u ? s : s * 4));
            acc(1'b1, 1'b0, {u[0], 21'h0}, 8'h00);
            if (s == 0) base = lat; else `CHK(lat - base, s)
        end
        $display("end of test: stretch");
        // Every strobe style and second strobe mode, both blocks
        for (int m = 0; m < 8; m++) begin
            style <= m[2];
            lb = m[1] & ~m[0];
            apb(1, `EMB_IDX_CFG_ONE, {1'b1, m[2], m[1], 5'h10});
            a = {m[0], 5'h0, 8'ha5, 8'h40 + m[7:0]};
            acc(1'b1, 1'b1, a, ~a[7:0]);
            `CHK(seen, {m[2] | lb, m[2] | ~lb, 1'b0})
            `CHK(addr_strobe_n_q, ~m[2])
            acc(1'b1, 1'b0, a, 8'h00);
            `CHK(seen, {lb, ~lb, 1'b1})
            `CHK(acc_rdata_q, ~a[7:0])
            `CHK(last_addr, a[15:0])
        end
        style <= 1'b0;
        // Internal access, toggle on, protection off: address moves, data strobes stay high
        apb(1, `EMB_IDX_CFG_ONE, 8'h94);
        protect_off <= 1'b1;
        acc(1'b0, 1'b0, 22'h003c5a, 8'h00);
        `CHK(seen[2:1], 2'b11)
        `CHK(last_addr, 16'h3c5a)
        protect_off <= 1'b0;
        apb(1, `EMB_IDX_CFG_ONE, 8'h90);
        $display("end of test: strobe modes");
        // Lower stretch of 3 keeps the cycle open past the wait filter
        apb(1, `EMB_IDX_CFG_TWO, 8'h1c);
        apb(1, `EMB_IDX_IRQ_VECTOR, 8'h02);
        acc(1'b1, 1'b0, 22'h0, 8'h00);
        base = lat;
        wait_len <= 4'd9;
        acc(1'b1, 1'b0, 22'h0, 8'h00);
        `CHK(lat - base inside {[4:12]}, 1'b1)
        wait_len <= 4'd0;
        $display("end of test: wait");
        // Request ignored while the function is off
        hold_cmd <= 1'b1;
        repeat (6) @(posedge clk);
        acc(1'b1, 1'b0, 22'h0, 8'h00);
        `CHK(grant_ack_n_q, 1'b1)
        apb(1, `EMB_IDX_CORE_MODE, 8'h02);
        fork
            acc(1'b1, 1'b1, 22'h0, 8'h3c);
            begin
                for (int i = 0; i < 40 && grant_ack_n_q !== 1'b0; i++) @(posedge clk);
                #1;
                `CHK({grant_ack_n_q, low_port_oe_q, high_port_oe_q, data_strobe_oe_q, rw_oe_q}, 5'h0)
                repeat (6) @(posedge clk);
                `CHK(grant_ack_n_q, 1'b0)
                hold_cmd <= 1'b0;
                for (int i = 0; i < 12 && grant_ack_n_q !== 1'b1; i++) @(posedge clk);
                #1;
                `CHK({grant_ack_n_q, low_port_oe_q, high_port_oe_q, data_strobe_oe_q}, 4'hf)
            end
        join
        $display("end of test: hold");
        tally_and_finish;
    end
endmodule

// ---- emb_map.vh ----
`ifndef EMB_MAP_VH
`define EMB_MAP_VH
// Register indexes; byte address is four times the index
`define EMB_IDX_CORE_MODE   8'heb
`define EMB_IDX_IRQ_VECTOR  8'hf2
`define EMB_IDX_STATUS      8'hf3
`define EMB_IDX_CFG_ONE     8'hf5
`define EMB_IDX_CFG_TWO     8'hf6
// Reset values
`define EMB_RST_CFG_ONE     8'h80
`define EMB_RST_CFG_TWO     8'h0f
`define EMB_RST_CORE_MODE   8'h00
`define EMB_RST_IRQ_VECTOR  8'h00
// Writable bits, others reserved; bit 7 of cfg one always reads one
`define EMB_WMASK_CFG_ONE   8'h76
`define EMB_WMASK_CFG_TWO   8'h7f
`define EMB_FIX_CFG_ONE     8'h80
// Field positions
`define EMB_BIT_HOLD_EN     1
`define EMB_BIT_WAIT_EN     1
`define EMB_BIT_STYLE       6
`define EMB_BIT_STROBE2     5
`define EMB_BIT_AS_ALT      4
`define EMB_BIT_TOGGLE      2
`define EMB_BIT_DRIVE       1
`define EMB_BIT_SEGFRAME    6
`define EMB_BIT_REMAP       5
`define EMB_BIT_MEMORY_SELECT      4
`define EMB_LAS_HI          3
`define EMB_LAS_LO          2
`define EMB_UAS_HI          1
`define EMB_UAS_LO          0
`define EMB_ADDR_BLOCK_BIT  21
`endif

// ---- emb_mem_model.sv ----
module emb_mem_model (
    input wire logic        clk, style, hold_cmd,                         // Clock, strobe style, hold command
    input wire logic [3:0]  wait_len,                                     // Wait cycles per access
    input wire logic        addr_strobe_n_q, data_strobe_n_q, lower_block_strobe_n_q, rw_q, // Strobes
    input wire logic [7:0]  low_port_out_q, high_port_out_q,              // Address and data out
    output logic     [7:0]  low_port_in,                                  // Read data to device
    output logic            wait_n, bus_hold_request_n,                   // Wait and hold pins
    output logic     [15:0] last_addr                                     // Latched address
);
    logic [7:0] mem [0:255];
    logic [7:0] last_q;
    logic       as_d;
    logic [3:0] wcnt;
    wire as_on = style ? addr_strobe_n_q : !addr_strobe_n_q;
    wire ds_on = !(data_strobe_n_q && lower_block_strobe_n_q);
    wire rd_on = rw_q && ds_on;
    wire wr_on = style ? !rw_q : (!rw_q && ds_on);

    initial begin
        wcnt = 4'h0;
        as_d = 1'b0;
        last_q = 8'h00;
        last_addr = 16'h0000;
    end
    // Outside master only asks when told to by the bench
    assign bus_hold_request_n = !hold_cmd;
    // Wait goes low as soon as the address shows, like a slow decoder
    assign wait_n = !((as_on && !as_d && wait_len != 4'h0) || wcnt != 4'h0);
    // Released bus shows the inverse of the last level, never stale data
    assign low_port_in = rd_on ? mem[last_addr[7:0]] : ~last_q;
    always @(posedge clk) begin
        as_d <= as_on;
        last_q <= low_port_in;
        if (as_on) last_addr <= {high_port_out_q, low_port_out_q};
        if (wr_on) mem[last_addr[7:0]] <= low_port_out_q;
        if (as_on && !as_d) wcnt <= wait_len;
        else if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
    end
endmodule
